// ---- logic/spbc_pkg.sv ----
// Overview of operation
// - four-bit count shown on four outputs
// - all state bits change on rising edge
// - clear low forces zero, highest priority
// - preset low loads data, enables ignored
// - both enables high increment the count
// - either enable low holds the count
// - plain modulo-16 counting, fifteen wraps zero
// - carry high only at fifteen with enable
// - control changes act only at edges, except carry enable on the carry output
// - enable transitions allowed at any level
package spbc_pkg;

  // ****************************************************************
  // counter
  // ****************************************************************
  localparam int unsigned    COUNT_W        = 4;
  localparam logic [3:0]     COUNT_CLEAR    = 4'h0;
  localparam logic [3:0]     COUNT_ONE      = 4'h1;
  localparam logic [3:0]     COUNT_TERMINAL = 4'hF;

  // ****************************************************************
  // register bus
  // ****************************************************************
  localparam int unsigned    APB_ADDR_W     = 12;
  localparam int unsigned    APB_DATA_W     = 32;
  localparam logic [31:0]    APB_ZERO       = 32'h0000_0000;

  localparam logic [11:0]    OFS_CMD        = 12'h000;
  localparam logic [11:0]    OFS_PRESET     = 12'h004;
  localparam logic [11:0]    OFS_STATUS     = 12'h008;
  localparam logic [11:0]    OFS_EVENTS     = 12'h00C;
  localparam logic [11:0]    OFS_WRAPS      = 12'h010;
  localparam logic [11:0]    OFS_MATCH      = 12'h014;
  localparam logic [11:0]    OFS_CAPTURE    = 12'h018;

  // command bits, write-only pulses
  localparam int unsigned    CMD_CLEAR_BIT   = 0;
  localparam int unsigned    CMD_LOAD_BIT    = 1;
  localparam int unsigned    CMD_CAPTURE_BIT = 2;

  // status fields
  localparam int unsigned    ST_COUNT_LSB   = 0;
  localparam int unsigned    ST_CARRY_BIT   = 4;
  localparam int unsigned    ST_CLEAR_BIT   = 5;
  localparam int unsigned    ST_LOAD_BIT    = 6;
  localparam int unsigned    ST_ENP_BIT     = 7;
  localparam int unsigned    ST_ENT_BIT     = 8;

  // sticky event bits, write one to clear
  localparam int unsigned    EVT_W          = 4;
  localparam int unsigned    EVT_WRAP_BIT   = 0;
  localparam int unsigned    EVT_CARRY_BIT  = 1;
  localparam int unsigned    EVT_MATCH_BIT  = 2;
  localparam int unsigned    EVT_CLEAR_BIT  = 3;
  localparam logic [3:0]     EVT_RST        = 4'h0;

  localparam int unsigned    WRAP_CNT_W     = 16;
  localparam logic [15:0]    WRAP_CNT_RST   = 16'h0000;
  localparam logic [15:0]    WRAP_CNT_ONE   = 16'h0001;
  localparam logic [15:0]    WRAP_CNT_MAX   = 16'hFFFF;

  localparam logic [3:0]     PRESET_RST     = 4'h0;
  localparam logic [3:0]     MATCH_RST      = 4'hF;
  localparam int unsigned    CAP_CARRY_BIT  = 4;
  localparam logic [4:0]     CAPTURE_RST    = 5'h00;

endpackage

// ---- logic/spbc_ctr_if.sv ----
`timescale 1ns/1ps
interface spbc_ctr_if;
  logic                              clearN;
  logic                              loadN;
  logic [spbc_pkg::COUNT_W-1:0]      presetVal;
  logic                              countEn;
  logic                              carryEn;
  logic [spbc_pkg::COUNT_W-1:0]      count;
  logic                              terminalCarry;
  logic                              stepping;

  modport core (
    input  clearN,
    input  loadN,
    input  presetVal,
    input  countEn,
    input  carryEn,
    output count,
    output terminalCarry,
    output stepping
  );

  modport ctl (
    output clearN,
    output loadN,
    output presetVal,
    output countEn,
    output carryEn,
    input  count,
    input  terminalCarry,
    input  stepping
  );
endinterface

// ---- logic/spbc_core.sv ----
`timescale 1ns/1ps
module spbc_core (
  input  wire logic  sys_clk,
  input  wire logic  rst_b,
  spbc_ctr_if.core   ctr
);

  // ****************************************************************
  // count state
  // ****************************************************************
  logic [spbc_pkg::COUNT_W-1:0] countQ;
  logic [spbc_pkg::COUNT_W-1:0] countD;
  logic                         stepOk;

  // the count takes its inputs only here, at the edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      countQ <= spbc_pkg::COUNT_CLEAR;
    end else begin
      countQ <= countD;
    end
  end

  assign stepOk = ctr.clearN & ctr.loadN & ctr.countEn & ctr.carryEn;

  always_comb begin
    if (!ctr.clearN) begin
      countD = spbc_pkg::COUNT_CLEAR;
    end else if (!ctr.loadN) begin
      countD = ctr.presetVal;
    end else if (ctr.countEn && ctr.carryEn) begin
      countD = countQ + spbc_pkg::COUNT_ONE;
    end else begin
      countD = countQ;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign ctr.count         = countQ;
  assign ctr.stepping      = stepOk;
  // no register stage, so a following stage sees it this cycle
  assign ctr.terminalCarry = ctr.carryEn & (countQ == spbc_pkg::COUNT_TERMINAL);

endmodule // spbc_core

// ---- logic/spbc_top.sv ----
`timescale 1ns/1ps
module spbc_top (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // counter pins
  input  wire logic         sync_clear_n,
  input  wire logic         preset_strobe_n,
  input  wire logic         preset_in_0,
  input  wire logic         preset_in_1,
  input  wire logic         preset_in_2,
  input  wire logic         preset_in_3,
  input  wire logic         parallel_count_enable,
  input  wire logic         carry_enable,
  output logic              count_out_0,
  output logic              count_out_1,
  output logic              count_out_2,
  output logic              count_out_3,
  output logic              terminal_carry_out
);

  // ****************************************************************
  // counter core
  // ****************************************************************
  spbc_ctr_if ctr ();

  spbc_core u_core (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .ctr     (ctr)
  );

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic        setupPhase;
  logic        accessPhase;
  logic        wrEn;
  logic        rdSetup;
  logic        hitCmd;
  logic        hitPreset;
  logic        hitStatus;
  logic        hitEvents;
  logic        hitWraps;
  logic        hitMatch;
  logic        hitCapture;
  logic        addrMapped;

  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign wrEn        = accessPhase & pwrite;
  assign rdSetup     = setupPhase & ~pwrite;

  assign hitCmd      = (paddr == spbc_pkg::OFS_CMD);
  assign hitPreset   = (paddr == spbc_pkg::OFS_PRESET);
  assign hitStatus   = (paddr == spbc_pkg::OFS_STATUS);
  assign hitEvents   = (paddr == spbc_pkg::OFS_EVENTS);
  assign hitWraps    = (paddr == spbc_pkg::OFS_WRAPS);
  assign hitMatch    = (paddr == spbc_pkg::OFS_MATCH);
  assign hitCapture  = (paddr == spbc_pkg::OFS_CAPTURE);

  assign addrMapped  = hitCmd | hitPreset | hitStatus | hitEvents
                     | hitWraps | hitMatch | hitCapture;

  // zero wait states; unmapped addresses answer with an error
  assign pready      = 1'b1;
  assign pslverr     = accessPhase & ~addrMapped;

  // ****************************************************************
  // software commands
  // ****************************************************************
  logic softClearQ;
  logic softLoadQ;
  logic softCaptureQ;

  // one-cycle pulses, applied at the edge after the write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      softClearQ <= 1'b0;
    end else begin
      softClearQ <= wrEn & hitCmd & pwdata[spbc_pkg::CMD_CLEAR_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      softLoadQ <= 1'b0;
    end else begin
      softLoadQ <= wrEn & hitCmd & pwdata[spbc_pkg::CMD_LOAD_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      softCaptureQ <= 1'b0;
    end else begin
      softCaptureQ <= wrEn & hitCmd & pwdata[spbc_pkg::CMD_CAPTURE_BIT];
    end
  end

  // ****************************************************************
  // preset and match registers
  // ****************************************************************
  logic [spbc_pkg::COUNT_W-1:0] presetQ;
  logic [spbc_pkg::COUNT_W-1:0] matchQ;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      presetQ <= spbc_pkg::PRESET_RST;
    end else if (wrEn && hitPreset) begin
      presetQ <= pwdata[spbc_pkg::COUNT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      matchQ <= spbc_pkg::MATCH_RST;
    end else if (wrEn && hitMatch) begin
      matchQ <= pwdata[spbc_pkg::COUNT_W-1:0];
    end
  end

  // ****************************************************************
  // drive the core
  // ****************************************************************
  logic [spbc_pkg::COUNT_W-1:0] pinPreset;

  assign pinPreset = {preset_in_3, preset_in_2, preset_in_1, preset_in_0};

  // pins come from same-clock logic, so no synchroniser
  assign ctr.clearN    = sync_clear_n & ~softClearQ;
  assign ctr.loadN     = preset_strobe_n & ~softLoadQ;
  // a strobe on the pin wins over the software preset value
  assign ctr.presetVal = preset_strobe_n ? presetQ : pinPreset;
  assign ctr.countEn   = parallel_count_enable;
  assign ctr.carryEn   = carry_enable;

  // ****************************************************************
  // pin outputs
  // ****************************************************************
  assign count_out_0        = ctr.count[0];
  assign count_out_1        = ctr.count[1];
  assign count_out_2        = ctr.count[2];
  assign count_out_3        = ctr.count[3];
  assign terminal_carry_out = ctr.terminalCarry;

  // ****************************************************************
  // sticky events
  // ****************************************************************
  logic [spbc_pkg::EVT_W-1:0] evtSet;
  logic [spbc_pkg::EVT_W-1:0] evtClr;
  logic [spbc_pkg::EVT_W-1:0] eventsQ;
  logic [spbc_pkg::EVT_W-1:0] eventsD;
  logic                       wrapNow;

  assign wrapNow = ctr.stepping & (ctr.count == spbc_pkg::COUNT_TERMINAL);

  always_comb begin
    evtSet                          = '0;
    evtSet[spbc_pkg::EVT_WRAP_BIT]  = wrapNow;
    evtSet[spbc_pkg::EVT_CARRY_BIT] = ctr.terminalCarry;
    evtSet[spbc_pkg::EVT_MATCH_BIT] = (ctr.count == matchQ);
    evtSet[spbc_pkg::EVT_CLEAR_BIT] = ~ctr.clearN;
  end

  assign evtClr  = (wrEn & hitEvents) ? pwdata[spbc_pkg::EVT_W-1:0] : '0;
  // a new event in the clearing cycle survives
  assign eventsD = (eventsQ & ~evtClr) | evtSet;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      eventsQ <= spbc_pkg::EVT_RST;
    end else begin
      eventsQ <= eventsD;
    end
  end

  // ****************************************************************
  // wrap counter
  // ****************************************************************
  logic [spbc_pkg::WRAP_CNT_W-1:0] wrapsQ;
  logic                            wrapsClr;

  assign wrapsClr = wrEn & hitWraps;

  // saturates; a wrap during the clearing write is kept
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrapsQ <= spbc_pkg::WRAP_CNT_RST;
    end else if (wrapsClr) begin
      wrapsQ <= wrapNow ? spbc_pkg::WRAP_CNT_ONE : spbc_pkg::WRAP_CNT_RST;
    end else if (wrapNow && (wrapsQ != spbc_pkg::WRAP_CNT_MAX)) begin
      wrapsQ <= wrapsQ + spbc_pkg::WRAP_CNT_ONE;
    end
  end

  // ****************************************************************
  // capture register
  // ****************************************************************
  logic [spbc_pkg::COUNT_W:0] captureQ;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      captureQ <= spbc_pkg::CAPTURE_RST;
    end else if (softCaptureQ) begin
      captureQ <= {ctr.terminalCarry, ctr.count};
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [31:0] statusWord;
  logic [31:0] readMux;
  logic [31:0] prdataQ;

  always_comb begin
    statusWord = spbc_pkg::APB_ZERO;
    statusWord[spbc_pkg::ST_COUNT_LSB +: spbc_pkg::COUNT_W] = ctr.count;
    statusWord[spbc_pkg::ST_CARRY_BIT] = ctr.terminalCarry;
    statusWord[spbc_pkg::ST_CLEAR_BIT] = sync_clear_n;
    statusWord[spbc_pkg::ST_LOAD_BIT]  = preset_strobe_n;
    statusWord[spbc_pkg::ST_ENP_BIT]   = parallel_count_enable;
    statusWord[spbc_pkg::ST_ENT_BIT]   = carry_enable;
  end

  always_comb begin
    readMux = spbc_pkg::APB_ZERO;
    if (hitPreset) begin
      readMux[spbc_pkg::COUNT_W-1:0] = presetQ;
    end else if (hitStatus) begin
      readMux = statusWord;
    end else if (hitEvents) begin
      readMux[spbc_pkg::EVT_W-1:0] = eventsQ;
    end else if (hitWraps) begin
      readMux[spbc_pkg::WRAP_CNT_W-1:0] = wrapsQ;
    end else if (hitMatch) begin
      readMux[spbc_pkg::COUNT_W-1:0] = matchQ;
    end else if (hitCapture) begin
      readMux[spbc_pkg::COUNT_W:0] = captureQ;
    end
  end

  // sampled in the setup cycle, held through the access cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdataQ <= spbc_pkg::APB_ZERO;
    end else if (rdSetup) begin
      prdataQ <= readMux;
    end
  end

  assign prdata = prdataQ;

endmodule // spbc_top

// ---- tb/spbc_asserts.sv ----
`timescale 1ns/1ps
module spbc_asserts (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        sync_clear_n,
  input wire logic        preset_strobe_n,
  input wire logic        preset_in_0,
  input wire logic        preset_in_1,
  input wire logic        preset_in_2,
  input wire logic        preset_in_3,
  input wire logic        parallel_count_enable,
  input wire logic        carry_enable,
  input wire logic        count_out_0,
  input wire logic        count_out_1,
  input wire logic        count_out_2,
  input wire logic        count_out_3,
  input wire logic        terminal_carry_out
);
  // ****************
  // helpers
  // ****************
  logic [3:0] cnt;
  logic [3:0] pre;
  logic       softW;
  logic       softQ;
  logic       run;
  assign cnt = {count_out_3, count_out_2, count_out_1, count_out_0};
  assign pre = {preset_in_3, preset_in_2, preset_in_1, preset_in_0};
  // soft clear or load command acts one edge late
  assign softW = psel & penable & pwrite & (paddr == spbc_pkg::OFS_CMD) & (|pwdata[1:0]);
  assign run = sync_clear_n & preset_strobe_n & parallel_count_enable & carry_enable & ~softQ;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) softQ <= 1'b0;
    else softQ <= softW;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ****************
  // properties
  // ****************
  chk_clear_zero:
    assert property (!sync_clear_n |=> cnt == 4'h0)
    else $error("count not zero after clear");
  chk_load_data:
    assert property (sync_clear_n && !preset_strobe_n && !softQ |=> cnt == $past(pre))
    else $error("count differs from preset data");
  chk_count_inc:
    assert property (run |=> cnt == $past(cnt) + 4'h1)
    else $error("count did not step by one");
  chk_inhibit_hold:
    assert property (sync_clear_n && preset_strobe_n && !softQ
                     && !(parallel_count_enable && carry_enable) |=> $stable(cnt))
    else $error("count moved while inhibited");
  chk_carry_term:
    assert property (terminal_carry_out == (carry_enable && cnt == 4'hF))
    else $error("carry out wrong for count");
  chk_carry_low:
    assert property (!carry_enable |-> !terminal_carry_out)
    else $error("carry out high while disabled");
  chk_wrap_zero:
    assert property (terminal_carry_out && run |=> cnt == 4'h0 && !terminal_carry_out)
    else $error("count did not wrap to zero");
  chk_count_run:
    assert property (run [*3] |=> cnt == $past(cnt, 3) + 4'h3)
    else $error("three counts gave wrong value");
endmodule // spbc_asserts

// ---- tb/spbc_far_stage.sv ----
`timescale 1ns/1ps
module spbc_far_stage #(
  parameter logic [3:0] DECODE_MAX = 4'h9
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       clearN,
  input  wire logic       countEn,
  input  wire logic       lowCarry,
  input  wire logic [3:0] lowCount,
  input  wire logic       decodeOn,
  output logic            decodeClearN,
  output logic [3:0]      highCount
);
  // ****************
  // upper stage
  // ****************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) highCount <= 4'h0;
    else if (!clearN) highCount <= 4'h0;
    else if (countEn && lowCarry) highCount <= highCount + 4'h1;
  end
  // active-low decode of the chosen top count
  assign decodeClearN = !(decodeOn && lowCount == DECODE_MAX);
endmodule // spbc_far_stage

// ---- tb/spbc_tb.sv ----
`timescale 1ns/1ps
module spbc_tb;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  ctl = 5'h0E;
  logic [3:0]  data = 4'h0;
  wire  [3:0]  cnt;
  wire         carry;
  logic        clrPin;
  logic        decClrN;
  logic [3:0]  highCount;
  logic [31:0] rd;
  logic        err;
  int          n_fail = 0;
  int          compares = 0;
  always #20 sys_clk = ~sys_clk;
  // ctl is {decode, clear_n, strobe_n, parallel enable, carry enable}
  assign clrPin = ctl[4] ? decClrN : ctl[3];
  spbc_top DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_clear_n(clrPin), .preset_strobe_n(ctl[2]), .preset_in_0(data[0]),
    .preset_in_1(data[1]), .preset_in_2(data[2]), .preset_in_3(data[3]),
    .parallel_count_enable(ctl[1]), .carry_enable(ctl[0]), .count_out_0(cnt[0]),
    .count_out_1(cnt[1]), .count_out_2(cnt[2]), .count_out_3(cnt[3]),
    .terminal_carry_out(carry));
  spbc_far_stage u_far (
    .sys_clk(sys_clk), .rst_b(rst_b), .clearN(clrPin), .countEn(ctl[1]), .lowCarry(carry),
    .lowCount(cnt), .decodeOn(ctl[4]), .decodeClearN(decClrN), .highCount(highCount));
  // ****************
  // tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // drives one cycle, checks the count the previous cycle produced and the carry under the new carry enable
  task automatic cyc(input logic [4:0] c, input logic [3:0] d, input logic [3:0] ec,
                     input logic ecy);
    @(posedge sys_clk);
    ctl <= c;
    data <= d;
    #1;
    chk("count", {28'h0, ec}, {28'h0, cnt});
    chk("carry", {31'h0, ecy}, {31'h0, carry});
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (1000) @(posedge sys_clk);
    n_fail++;
    $display("mismatch watchdog exp done got hang");
    conclude();
  end
  // ****************
  // tests
  // ****************
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b0, spbc_pkg::OFS_MATCH, 32'h0000_0000);
    chk("match reset", 32'h0000_000F, rd);
    chk("mapped err", 32'h0000_0000, {31'h0, err});
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    chk("unmapped rd", 32'h0000_0000, rd);
    apb(1'b1, spbc_pkg::OFS_PRESET, 32'h0000_0007);
    apb(1'b0, spbc_pkg::OFS_PRESET, 32'h0000_0000);
    chk("preset rw", 32'h0000_0007, rd);
    apb(1'b1, spbc_pkg::OFS_CMD, 32'h0000_0002);
    cyc(5'h0E, 4'h0, 4'h7, 1'b0);
    apb(1'b0, spbc_pkg::OFS_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_00E7, rd);
    apb(1'b1, spbc_pkg::OFS_CMD, 32'h0000_0001);
    cyc(5'h0E, 4'h0, 4'h0, 1'b0);
    $display("test registers done");
    cyc(5'h07, 4'h0, 4'h0, 1'b0);
    cyc(5'h0B, 4'hC, 4'h0, 1'b0);
    for (int i = 0; i < 7; i++) cyc(5'h0F, 4'h0, 4'hC + 4'(i), i == 3);
    cyc(5'h0D, 4'h0, 4'h3, 1'b0);
    cyc(5'h0E, 4'h0, 4'h3, 1'b0);
    cyc(5'h0C, 4'h0, 4'h3, 1'b0);
    cyc(5'h03, 4'h5, 4'h3, 1'b0);
    cyc(5'h08, 4'hF, 4'h0, 1'b0);
    cyc(5'h0D, 4'h0, 4'hF, 1'b1);
    cyc(5'h0E, 4'h0, 4'hF, 1'b0);
    cyc(5'h07, 4'h0, 4'hF, 1'b1);
    $display("test walk done");
    for (int i = 0; i < 20; i++) cyc(5'h0F, 4'h0, 4'(i), i == 15);
    cyc(5'h0E, 4'h0, 4'h4, 1'b0);
    chk("upper stage", 32'h0000_0001, {28'h0, highCount});
    $display("test cascade done");
    cyc(5'h07, 4'h0, 4'h4, 1'b0);
    for (int i = 0; i < 12; i++) cyc(5'h1F, 4'h0, 4'(i % 10), 1'b0);
    $display("test decode done");
    cyc(5'h09, 4'hF, 4'h2, 1'b0);
    cyc(5'h0D, 4'h0, 4'hF, 1'b1);
    apb(1'b1, spbc_pkg::OFS_CMD, 32'h0000_0004);
    apb(1'b0, spbc_pkg::OFS_CAPTURE, 32'h0000_0000);
    chk("capture", 32'h0000_001F, rd);
    apb(1'b0, spbc_pkg::OFS_WRAPS, 32'h0000_0000);
    chk("wraps", 32'h0000_0002, rd);
    apb(1'b1, spbc_pkg::OFS_WRAPS, 32'h0000_0000);
    apb(1'b0, spbc_pkg::OFS_WRAPS, 32'h0000_0000);
    chk("wraps clear", 32'h0000_0000, rd);
    apb(1'b0, spbc_pkg::OFS_EVENTS, 32'h0000_0000);
    chk("events", 32'h0000_000F, rd);
    apb(1'b1, spbc_pkg::OFS_EVENTS, 32'h0000_000F);
    apb(1'b0, spbc_pkg::OFS_EVENTS, 32'h0000_0000);
    chk("events held", 32'h0000_0006, rd);
    apb(1'b1, spbc_pkg::OFS_MATCH, 32'h0000_0005);
    apb(1'b0, spbc_pkg::OFS_MATCH, 32'h0000_0000);
    chk("match rw", 32'h0000_0005, rd);
    $display("test status regs done");
    conclude();
  end
endmodule // spbc_tb
bind spbc_top spbc_asserts u_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .sync_clear_n(sync_clear_n),
  .preset_strobe_n(preset_strobe_n), .preset_in_0(preset_in_0), .preset_in_1(preset_in_1),
  .preset_in_2(preset_in_2), .preset_in_3(preset_in_3),
  .parallel_count_enable(parallel_count_enable), .carry_enable(carry_enable),
  .count_out_0(count_out_0), .count_out_1(count_out_1), .count_out_2(count_out_2),
  .count_out_3(count_out_3), .terminal_carry_out(terminal_carry_out));
